// [accel_pkg.sv]
// constants for the accelerometer mode, range and level-detect control
package accel_pkg;
   // register addresses
   localparam logic [7:0] ADDR_X10_LO    = 8'h00;
   localparam logic [7:0] ADDR_X10_HI    = 8'h01;
   localparam logic [7:0] ADDR_Y10_LO    = 8'h02;
   localparam logic [7:0] ADDR_Y10_HI    = 8'h03;
   localparam logic [7:0] ADDR_Z10_LO    = 8'h04;
   localparam logic [7:0] ADDR_Z10_HI    = 8'h05;
   localparam logic [7:0] ADDR_X8        = 8'h06;
   localparam logic [7:0] ADDR_Y8        = 8'h07;
   localparam logic [7:0] ADDR_Z8        = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h09;
   localparam logic [7:0] ADDR_MODE      = 8'h16;
   localparam logic [7:0] ADDR_CTL1      = 8'h18;
   localparam logic [7:0] ADDR_CTL2      = 8'h19;
   localparam logic [7:0] ADDR_LEVEL_THR = 8'h1A;
   localparam logic [7:0] REG_RESET      = 8'h00;

   // mode_control fields
   localparam int          MODE_LSB       = 0;
   localparam int          RANGE_LSB      = 2;
   localparam int          SELF_TEST_BIT  = 4;
   localparam logic [1:0]  MODE_STANDBY   = 2'h0;
   localparam logic [1:0]  MODE_MEASURE   = 2'h1;
   localparam logic [1:0]  MODE_LEVEL     = 2'h2;
   localparam logic [1:0]  MODE_PULSE     = 2'h3;
   localparam logic [1:0]  RANGE_8G       = 2'h0;
   localparam logic [1:0]  RANGE_2G       = 2'h1;
   localparam logic [1:0]  RANGE_4G       = 2'h2;

   // detect_control_one / two fields
   localparam int X_DISABLE_BIT   = 3;
   localparam int Y_DISABLE_BIT   = 4;
   localparam int Z_DISABLE_BIT   = 5;
   localparam int THR_SIGN_BIT    = 6;
   localparam int FILTER_BW_BIT   = 7;
   localparam int LEVEL_POL_BIT   = 0;

   // status fields
   localparam int STATUS_READY_BIT   = 0;
   localparam int STATUS_OVERRUN_BIT = 1;

   // data formats
   localparam int                 RAW_W        = 10;
   localparam int                 OUT_W        = 8;
   localparam int                 THR_MAG_W    = 7;
   localparam logic signed [10:0] SELF_TEST_Z  = 11'sh040;
   localparam logic signed [10:0] RAW_MAX      = 11'sh1FF;
   localparam logic signed [10:0] RAW_MIN      = -11'sh200;
   localparam logic signed [9:0]  OUT8_MAX     = 10'sh07F;
   localparam logic signed [9:0]  OUT8_MIN     = -10'sh080;

   // timing
   localparam int CLK_HZ          = 200_000_000;
   localparam int RATE_BW_LO_HZ   = 125;
   localparam int RATE_BW_HI_HZ   = 250;
   localparam int DETECT_BW_HZ    = 600;
   localparam int DETECT_RATE_HZ  = 2 * DETECT_BW_HZ;
   localparam int MEAS_LO_CYCLES  = CLK_HZ / RATE_BW_LO_HZ;
   localparam int MEAS_HI_CYCLES  = CLK_HZ / RATE_BW_HI_HZ;
   localparam int DETECT_CYCLES   = CLK_HZ / DETECT_RATE_HZ;
   localparam int PULSE_STEP_US   = 500;
   localparam int TIMER_STEP_US   = 1000;
   localparam int PULSE_STEP_CYCLES = (CLK_HZ / 1_000_000) * PULSE_STEP_US;
   localparam int TIMER_STEP_CYCLES = (CLK_HZ / 1_000_000) * TIMER_STEP_US;
   localparam int PULSE_DUR_MIN_STEPS = 1;
   localparam int PULSE_DUR_MAX_STEPS = 254;
   localparam int LATENCY_MAX_STEPS   = 150;
   localparam int WINDOW_MAX_STEPS    = 250;
   localparam int TIMER_MIN_STEPS     = 1;
endpackage

// [accel_mode_and_level_detect.sv]
// accelerometer mode, range, sample-ready and level-detect control
// Summary of operation
// RQ1: two-bit mode: standby, measure, level, pulse
// RQ2: range code sets 8g, 2g, 4g scaling
// RQ3: range changes apply at once, no mode change
// RQ4: self-test shifts Z output by 1g
// RQ5: standby keeps registers, stops new samples
// RQ6: measure samples continuously, detect interrupts held off
// RQ7: measure rate 125 Hz or 250 Hz
// RQ8: 8-bit has all ranges, 10-bit 8g only
// RQ9: ready pin set, cleared by output read
// RQ10: ready mirrored in status register bit
// RQ11: unread sample overwritten sets overrun bit
// RQ12: level mode: data readable, level interrupt, no timers
// RQ13: level interrupt stays high until cleared
// RQ14: level detection always uses 8g scaling
// RQ15: axis-disable bits D3..D5, reset enabled
// RQ16: compare absolute or signed axis values
// RQ17: motion any-above, freefall all-below
// RQ18: pulse duration 0.5 ms steps up to 127 ms
// RQ19: latency and window in 1 ms steps
// RQ20: threshold resolves 127 count levels
// RQ21: detect modes use 600 Hz bandwidth rate
// RQ22: filter bit picks 62.5 or 125 Hz bandwidth
// RQ23: threshold option: absolute 0, signed 1
// RQ24: polarity: OR above 0, AND below 1
// RQ25: mode register resets to zero
module accel_mode_and_level_detect #(
   parameter int MEAS_LO_CYCLES    = accel_pkg::MEAS_LO_CYCLES,
   parameter int MEAS_HI_CYCLES    = accel_pkg::MEAS_HI_CYCLES,
   parameter int DETECT_CYCLES     = accel_pkg::DETECT_CYCLES,
   parameter int PULSE_STEP_CYCLES = accel_pkg::PULSE_STEP_CYCLES,
   parameter int TIMER_STEP_CYCLES = accel_pkg::TIMER_STEP_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire logic                clk_en,
   input  wire logic signed [9:0]   x_raw,
   input  wire logic signed [9:0]   y_raw,
   input  wire logic signed [9:0]   z_raw,
   input  wire logic [7:0]          reg_addr,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [7:0]          reg_wdata,
   output logic [7:0]               reg_rdata,
   output logic                     sample_ready,
   output logic                     level_irq,
   input  wire logic                level_irq_clear,
   output logic                     front_end_on,
   output logic                     pulse_step_tick,
   output logic                     timer_step_tick
);
   localparam int CNT_W = 21;

   typedef struct packed {
      logic [7:0]       mode_control;
      logic [7:0]       detect_control_one;
      logic [7:0]       detect_control_two;
      logic [7:0]       level_threshold;
      logic [9:0]       x_val;
      logic [9:0]       y_val;
      logic [9:0]       z_val;
      logic [7:0]       rdata;
      logic             ready;
      logic             overrun;
      logic             level_hit;
      logic [CNT_W-1:0] sample_cnt;
      logic [CNT_W-1:0] pulse_cnt;
      logic [CNT_W-1:0] timer_cnt;
      logic             pulse_tick;
      logic             timer_tick;
   } state_t;

   state_t s;
   state_t next_s;

   // clamp a 10-bit value into the signed 8-bit output format
   function automatic logic [7:0] sat8(input logic signed [9:0] v);
      if (v > accel_pkg::OUT8_MAX) begin
         return 8'h7F;
      end else if (v < accel_pkg::OUT8_MIN) begin
         return 8'h80;
      end
      return v[7:0];
   endfunction

   // raw is 64 counts/g over 8g; scale to the selected 8-bit range
   function automatic logic [7:0] scale8(input logic [9:0] raw,
                                         input logic [1:0] rng);
      logic signed [9:0] r;
      r = $signed(raw);
      unique case (rng)
         accel_pkg::RANGE_2G: return sat8(r);                 // RQ2
         accel_pkg::RANGE_4G: return sat8(r >>> 1);           // RQ2
         default:             return r[9:2];                  // RQ2
      endcase
   endfunction

   // per-axis threshold test on the 8g scale; {above, below}
   function automatic logic [1:0] axis_cmp(input logic [9:0] raw,
                                           input logic       signed_opt,
                                           input logic [7:0] thr);
      logic signed [7:0] d;
      logic signed [9:0] a;
      logic signed [9:0] t;
      d = raw[9:2];                                           // RQ14
      if (signed_opt) begin                                   // RQ16 RQ23
         a = {{2{d[7]}}, d};
         t = {{2{thr[7]}}, thr};
      end else begin
         a = d[7] ? 10'(-$signed({d[7], d})) : {2'b00, d};
         t = {3'b000, thr[accel_pkg::THR_MAG_W-1:0]};         // RQ20
      end
      return {a > t, a < t};
   endfunction

   logic [1:0]       op_mode;
   logic             detect_mode;
   logic             take;
   logic             out_rd;
   logic [CNT_W-1:0] period_m1;
   logic [9:0]       z_new;
   logic signed [10:0] z_sum;
   logic [2:0]       enabled;
   logic [2:0]       above;
   logic [2:0]       below;
   logic             level_cond;

   assign op_mode     = s.mode_control[accel_pkg::MODE_LSB +: 2];
   assign detect_mode = (op_mode == accel_pkg::MODE_LEVEL) ||
                        (op_mode == accel_pkg::MODE_PULSE);
   assign out_rd      = reg_rd && (reg_addr <= accel_pkg::ADDR_Z8);
   assign enabled     = ~{s.detect_control_one[accel_pkg::Z_DISABLE_BIT],
                          s.detect_control_one[accel_pkg::Y_DISABLE_BIT],
                          s.detect_control_one[accel_pkg::X_DISABLE_BIT]};

   always_comb begin
      // detection runs faster than the measurement filters allow
      if (detect_mode) begin
         period_m1 = CNT_W'(DETECT_CYCLES - 1);               // RQ21
      end else if (s.detect_control_one[accel_pkg::FILTER_BW_BIT]) begin
         period_m1 = CNT_W'(MEAS_HI_CYCLES - 1);              // RQ7 RQ22
      end else begin
         period_m1 = CNT_W'(MEAS_LO_CYCLES - 1);              // RQ7 RQ22
      end
   end

   assign take = (op_mode != accel_pkg::MODE_STANDBY) &&
                 (s.sample_cnt >= period_m1);                 // RQ5 RQ6

   // self-test stimulus adds 1g to Z, saturating at full scale
   always_comb begin
      z_sum = 11'(z_raw) + accel_pkg::SELF_TEST_Z;             // RQ4
      if (!s.mode_control[accel_pkg::SELF_TEST_BIT]) begin
         z_new = z_raw;
      end else if (z_sum > accel_pkg::RAW_MAX) begin
         z_new = accel_pkg::RAW_MAX[9:0];
      end else begin
         z_new = z_sum[9:0];
      end
   end

   always_comb begin
      logic [1:0] cx;
      logic [1:0] cy;
      logic [1:0] cz;
      logic       pol;
      cx = axis_cmp(x_raw, s.detect_control_one[accel_pkg::THR_SIGN_BIT],
                    s.level_threshold);
      cy = axis_cmp(y_raw, s.detect_control_one[accel_pkg::THR_SIGN_BIT],
                    s.level_threshold);
      cz = axis_cmp(z_new, s.detect_control_one[accel_pkg::THR_SIGN_BIT],
                    s.level_threshold);
      pol   = s.detect_control_two[accel_pkg::LEVEL_POL_BIT];
      above = {cz[1], cy[1], cx[1]} & enabled;                // RQ15
      below = {cz[0], cy[0], cx[0]} | ~enabled;               // RQ15
      // with no axis enabled neither condition can fire
      if (pol) begin
         level_cond = (&below) && (|enabled);                 // RQ17 RQ24
      end else begin
         level_cond = |above;                                 // RQ17 RQ24
      end
   end

   always_comb begin
      next_s            = s;
      next_s.pulse_tick = 1'b0;
      next_s.timer_tick = 1'b0;

      if (take) begin
         next_s.sample_cnt = '0;
      end else if (op_mode == accel_pkg::MODE_STANDBY) begin
         next_s.sample_cnt = '0;                              // RQ5
      end else begin
         next_s.sample_cnt = s.sample_cnt + CNT_W'(1);
      end

      // read clears first so a sample landing together wins
      if (out_rd) begin
         next_s.ready   = 1'b0;                               // RQ9
         next_s.overrun = 1'b0;
      end
      if (take) begin
         next_s.x_val = x_raw;
         next_s.y_val = y_raw;
         next_s.z_val = z_new;                                // RQ4
         next_s.ready = 1'b1;                                 // RQ9
         if (s.ready) begin
            next_s.overrun = 1'b1;                            // RQ11
         end
      end

      // level flag is sticky; new hit beats a clear in the same cycle
      if (level_irq_clear) begin
         next_s.level_hit = 1'b0;                             // RQ13
      end
      if (take && detect_mode && level_cond) begin
         next_s.level_hit = 1'b1;                             // RQ12 RQ13
      end
      if (!detect_mode) begin
         next_s.level_hit = 1'b0;                             // RQ6
      end

      // pulse timebases run only in pulse mode; level mode has none
      if (op_mode != accel_pkg::MODE_PULSE) begin
         next_s.pulse_cnt = '0;                               // RQ12
         next_s.timer_cnt = '0;
      end else begin
         if (s.pulse_cnt >= CNT_W'(PULSE_STEP_CYCLES - 1)) begin
            next_s.pulse_cnt  = '0;
            next_s.pulse_tick = 1'b1;                         // RQ18
         end else begin
            next_s.pulse_cnt = s.pulse_cnt + CNT_W'(1);
         end
         if (s.timer_cnt >= CNT_W'(TIMER_STEP_CYCLES - 1)) begin
            next_s.timer_cnt  = '0;
            next_s.timer_tick = 1'b1;                         // RQ19
         end else begin
            next_s.timer_cnt = s.timer_cnt + CNT_W'(1);
         end
      end

      if (reg_wr) begin
         unique case (reg_addr)
            accel_pkg::ADDR_MODE:      next_s.mode_control = reg_wdata; // RQ1 RQ3
            accel_pkg::ADDR_CTL1:      next_s.detect_control_one = reg_wdata;
            accel_pkg::ADDR_CTL2:      next_s.detect_control_two = reg_wdata;
            accel_pkg::ADDR_LEVEL_THR: next_s.level_threshold = reg_wdata;
            default: ;
         endcase
      end

      if (reg_rd) begin
         unique case (reg_addr)
            accel_pkg::ADDR_X10_LO: next_s.rdata = s.x_val[7:0];     // RQ8
            accel_pkg::ADDR_X10_HI: next_s.rdata = {{6{s.x_val[9]}}, s.x_val[9:8]};
            accel_pkg::ADDR_Y10_LO: next_s.rdata = s.y_val[7:0];
            accel_pkg::ADDR_Y10_HI: next_s.rdata = {{6{s.y_val[9]}}, s.y_val[9:8]};
            accel_pkg::ADDR_Z10_LO: next_s.rdata = s.z_val[7:0];
            accel_pkg::ADDR_Z10_HI: next_s.rdata = {{6{s.z_val[9]}}, s.z_val[9:8]};
            accel_pkg::ADDR_X8: next_s.rdata = scale8(s.x_val,
               s.mode_control[accel_pkg::RANGE_LSB +: 2]);       // RQ3
            accel_pkg::ADDR_Y8: next_s.rdata = scale8(s.y_val,
               s.mode_control[accel_pkg::RANGE_LSB +: 2]);
            accel_pkg::ADDR_Z8: next_s.rdata = scale8(s.z_val,
               s.mode_control[accel_pkg::RANGE_LSB +: 2]);
            accel_pkg::ADDR_STATUS: next_s.rdata = {6'h00, s.overrun,
                                                    s.ready};   // RQ10
            accel_pkg::ADDR_MODE:      next_s.rdata = s.mode_control;
            accel_pkg::ADDR_CTL1:      next_s.rdata = s.detect_control_one;
            accel_pkg::ADDR_CTL2:      next_s.rdata = s.detect_control_two;
            accel_pkg::ADDR_LEVEL_THR: next_s.rdata = s.level_threshold;
            default:                   next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;                                             // RQ25 RQ15
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign reg_rdata       = s.rdata;
   assign sample_ready    = s.ready;                          // RQ9
   assign level_irq       = s.level_hit;
   assign front_end_on    = (op_mode != accel_pkg::MODE_STANDBY); // RQ5
   assign pulse_step_tick = s.pulse_tick;
   assign timer_step_tick = s.timer_tick;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_sample_taken;
      clk_en && take;
   endsequence

   sequence s_clean_read;
      clk_en && out_rd && !take;
   endsequence

   a_standby_no_take: assert property ( // RQ5
      clk_en && op_mode == accel_pkg::MODE_STANDBY |=> !$rose(sample_ready))
      else $error("sample taken in standby");
   a_ready_on_sample: assert property ( // RQ9
      s_sample_taken |=> sample_ready)
      else $error("ready not set after sample");
   a_ready_read_clear: assert property ( // RQ9
      s_clean_read |=> !sample_ready)
      else $error("ready not cleared by output read");
   a_status_mirror: assert property ( // RQ10
      clk_en && reg_rd && reg_addr == accel_pkg::ADDR_STATUS
      |=> reg_rdata[accel_pkg::STATUS_READY_BIT] == $past(sample_ready))
      else $error("status ready bit does not mirror pin");
   a_overrun_set: assert property ( // RQ11
      s_sample_taken and (sample_ready) |=> s.overrun)
      else $error("overrun not set on unread sample");
   a_measure_irq_off: assert property ( // RQ6
      clk_en && op_mode == accel_pkg::MODE_MEASURE |=> !level_irq)
      else $error("level interrupt active in measurement mode");
   a_irq_held: assert property ( // RQ13
      clk_en && level_irq && !level_irq_clear && detect_mode &&
      !(reg_wr && reg_addr == accel_pkg::ADDR_MODE) |=> level_irq)
      else $error("level interrupt dropped without clear");
   a_self_test_z: assert property ( // RQ4
      s_sample_taken and (s.mode_control[accel_pkg::SELF_TEST_BIT] &&
      z_raw < 10'sd100) |=> $signed(s.z_val) == $past(z_raw) + 10'sd64)
      else $error("self-test Z shift wrong");
   a_range_8g_read: assert property ( // RQ2
      clk_en && reg_rd && reg_addr == accel_pkg::ADDR_X8 &&
      s.mode_control[accel_pkg::RANGE_LSB +: 2] == accel_pkg::RANGE_8G
      |=> reg_rdata == $past(s.x_val[9:2]))
      else $error("8g readback scaling wrong");
   a_no_pulse_tick: assert property ( // RQ12
      op_mode != accel_pkg::MODE_PULSE ##1 clk_en |=> !pulse_step_tick)
      else $error("pulse timebase runs outside pulse mode");
endmodule

// [host_model.sv]
// host-side register master driving the block's register port
module host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // idle bus shows inverted values so a stale address never looks valid
   task automatic release_bus();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      release_bus();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      release_bus();
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
endmodule

// [tb.sv]
// self-checking bench for the mode, range and level-detect block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LO = 40;
   localparam int HI = 20;
   localparam int DET = 10;
   localparam int LIMIT = 20000;

   logic              sys_clk = 1'b0;
   logic              resetn;
   logic              clk_en;
   logic signed [9:0] x_raw;
   logic signed [9:0] y_raw;
   logic signed [9:0] z_raw;
   logic [7:0]        reg_addr;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_wdata;
   logic [7:0]        reg_rdata;
   logic              sample_ready;
   logic              level_irq;
   logic              level_irq_clear;
   logic              front_end_on;
   logic              pulse_step_tick;
   logic              timer_step_tick;
   int                cyc = 0;
   int                error_cnt = 0;
   int                check_count = 0;

   always #2.5 sys_clk = ~sys_clk;

   accel_mode_and_level_detect #(
      .MEAS_LO_CYCLES(LO), .MEAS_HI_CYCLES(HI), .DETECT_CYCLES(DET),
      .PULSE_STEP_CYCLES(8), .TIMER_STEP_CYCLES(16)
   ) dut (
      .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
      .x_raw(x_raw), .y_raw(y_raw), .z_raw(z_raw),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_ready(sample_ready), .level_irq(level_irq),
      .level_irq_clear(level_irq_clear), .front_end_on(front_end_on),
      .pulse_step_tick(pulse_step_tick), .timer_step_tick(timer_step_tick)
   );

   host_model hm (
      .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata)
   );

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      hm.rd(a, d);
      check(d, exp);
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return sample_ready;
         1: return level_irq;
         2: return pulse_step_tick;
         default: return timer_step_tick;
      endcase
   endfunction

   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (pick(sel) !== 1'b1 && n < lim);
      check({7'h00, pick(sel)}, 8'h01);
   endtask

   task automatic stay(input int sel, input int n, input logic v);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge sys_clk);
         if (pick(sel) !== v) ok = 1'b0;
      end
      check({7'h00, ok}, 8'h01);
   endtask

   // two reads, since a sample landing on the first read wins over it
   task automatic fresh();
      logic [7:0] d;
      hm.rd(accel_pkg::ADDR_X10_LO, d);
      hm.rd(accel_pkg::ADDR_X10_LO, d);
      wait_hi(0, LO + 5);
   endtask

   task automatic set_x(input logic signed [9:0] v);
      @(posedge sys_clk);
      x_raw <= v;
   endtask

   task automatic clr_irq();
      @(posedge sys_clk);
      level_irq_clear <= 1'b1;
      @(posedge sys_clk);
      level_irq_clear <= 1'b0;
   endtask

   task automatic t_reset();
      check({7'h00, sample_ready}, 8'h00);
      check({7'h00, front_end_on}, 8'h00);
      rd_chk(accel_pkg::ADDR_MODE, 8'h00);
      rd_chk(accel_pkg::ADDR_CTL1, 8'h00);
      rd_chk(8'h30, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_measure();
      logic [7:0] mv [3] = '{8'h01, 8'h05, 8'h09};
      logic [7:0] xe [3] = '{8'h10, 8'h40, 8'h20};
      set_x(10'sh040);
      hm.wr(accel_pkg::ADDR_MODE, 8'h01);
      @(negedge sys_clk);
      check({7'h00, front_end_on}, 8'h01);
      wait_hi(0, LO + 5);
      rd_chk(accel_pkg::ADDR_STATUS, 8'h01);
      check({7'h00, level_irq}, 8'h00);
      repeat (LO) @(negedge sys_clk);
      rd_chk(accel_pkg::ADDR_STATUS, 8'h03);
      rd_chk(accel_pkg::ADDR_X8, 8'h10);
      check({7'h00, sample_ready}, 8'h00);
      rd_chk(accel_pkg::ADDR_STATUS, 8'h00);
      for (int i = 0; i < 3; i++) begin
         hm.wr(accel_pkg::ADDR_MODE, mv[i]);
         fresh();
         rd_chk(accel_pkg::ADDR_X8, xe[i]);
         rd_chk(accel_pkg::ADDR_X10_LO, 8'h40);
      end
      hm.wr(accel_pkg::ADDR_MODE, 8'h11);
      fresh();
      rd_chk(accel_pkg::ADDR_Z8, 8'h10);
      rd_chk(accel_pkg::ADDR_Z10_LO, 8'h40);
      $display("measure test done");
   endtask

   task automatic t_rate();
      logic [7:0] cv [4] = '{8'h00, 8'h80, 8'h00, 8'h80};
      logic [7:0] mv [4] = '{8'h01, 8'h01, 8'h02, 8'h03};
      int         pe [4] = '{LO, HI, DET, DET};
      int         t0;
      for (int i = 0; i < 4; i++) begin
         // restart from standby so the counter never runs past a period
         hm.wr(accel_pkg::ADDR_MODE, 8'h00);
         hm.wr(accel_pkg::ADDR_CTL1, cv[i]);
         hm.wr(accel_pkg::ADDR_MODE, mv[i]);
         fresh();
         t0 = cyc;
         fresh();
         check(8'(cyc - t0), 8'(pe[i]));
      end
      wait_hi(2, 20);
      t0 = cyc;
      wait_hi(2, 20);
      check(8'(cyc - t0), 8'h08);
      wait_hi(3, 40);
      t0 = cyc;
      wait_hi(3, 40);
      check(8'(cyc - t0), 8'h10);
      $display("rate test done");
   endtask

   task automatic t_standby();
      logic [7:0] d;
      hm.wr(accel_pkg::ADDR_MODE, 8'h00);
      hm.rd(accel_pkg::ADDR_X10_LO, d);
      check({7'h00, front_end_on}, 8'h00);
      stay(0, 2 * LO, 1'b0);
      hm.wr(accel_pkg::ADDR_LEVEL_THR, 8'h5A);
      rd_chk(accel_pkg::ADDR_LEVEL_THR, 8'h5A);
      $display("standby test done");
   endtask

   task automatic t_level();
      hm.wr(accel_pkg::ADDR_CTL1, 8'h00);
      hm.wr(accel_pkg::ADDR_LEVEL_THR, 8'h2F);
      set_x(10'sh0C8);
      hm.wr(accel_pkg::ADDR_MODE, 8'h02);
      wait_hi(1, DET + 5);
      set_x(10'sh000);
      stay(1, 2 * DET, 1'b1);
      clr_irq();
      stay(1, 2 * DET, 1'b0);
      hm.wr(accel_pkg::ADDR_CTL1, 8'h08);
      set_x(10'sh0C8);
      stay(1, 2 * DET, 1'b0);
      // flip the sign while X is still masked, so no stray hit latches
      set_x(-10'sh0C8);
      hm.wr(accel_pkg::ADDR_CTL1, 8'h40);
      stay(1, 2 * DET, 1'b0);
      hm.wr(accel_pkg::ADDR_CTL1, 8'h00);
      wait_hi(1, DET + 5);
      // 25 counts at 8g would read as 100 if the 2g scale leaked in
      set_x(10'sh064);
      clr_irq();
      hm.wr(accel_pkg::ADDR_MODE, 8'h06);
      stay(1, 2 * DET, 1'b0);
      // park in standby so a half-set level condition cannot latch
      hm.wr(accel_pkg::ADDR_MODE, 8'h00);
      hm.wr(accel_pkg::ADDR_LEVEL_THR, 8'h07);
      set_x(10'sh0C8);
      hm.wr(accel_pkg::ADDR_CTL2, 8'h01);
      hm.wr(accel_pkg::ADDR_MODE, 8'h06);
      stay(1, 2 * DET, 1'b0);
      set_x(10'sh000);
      wait_hi(1, DET + 5);
      hm.wr(accel_pkg::ADDR_MODE, 8'h01);
      @(posedge sys_clk);
      stay(1, 2 * DET, 1'b0);
      $display("level test done");
   endtask

   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      x_raw = 10'sh000;
      y_raw = 10'sh000;
      z_raw = 10'sh000;
      level_irq_clear = 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      t_reset();
      t_measure();
      t_rate();
      t_standby();
      t_level();
      test_done();
   end
endmodule
